// >>> core/sda_consts.svh
// Constants for the sigma-delta converter serial link and its host controller
`ifndef SDA_CONSTS_SVH
`define SDA_CONSTS_SVH
`define SDA_SEL_COMM 3'h0
`define SDA_SEL_SETUP 3'h1
`define SDA_SEL_CLOCK 3'h2
`define SDA_SEL_DATA 3'h3
`define SDA_SEL_TEST 3'h4
`define SDA_SEL_NOP 3'h5
`define SDA_SEL_OFFS 3'h6
`define SDA_SEL_GAIN 3'h7
`define SDA_W8 5'h08
`define SDA_W16 5'h10
`define SDA_W24 5'h18
`define SDA_SETUP_RST 8'h01
`define SDA_CLOCK_RST 8'h05
`define SDA_OFFS_RST 24'h1F4000
`define SDA_GAIN_RST 24'h5761AB
`define SDA_SETUP_HOLD 0
`define SDA_SETUP_UNI 2
`define SDA_CLOCK_BASE 2
`define SDA_CLOCK_HALVE 3
`define SDA_CMD_RW 3
`define SDA_MOD_DIV_M1 8'h7F
`define SDA_MOD_DIV2_M1 8'hFF
`define SDA_LOG2N_BASE 4'h5
`define SDA_SETTLE_LAST 2'h2
`define SDA_ONES_LAST 6'h1F
`define SDA_SCLK_HALF_M1 4'h7
`define SDA_A_CMD 8'h00
`define SDA_A_TX 8'h04
`define SDA_A_RX 8'h08
`define SDA_A_STAT 8'h0C
`define SDA_A_CTRL 8'h10
`define SDA_OKAY 2'h0
`define SDA_SLVERR 2'h2
`endif

// >>> core/sda_pkg.sv
// Types and shared decode for the converter link
package sda_pkg;
  `include "sda_consts.svh"
  typedef enum logic [1:0] {DEV_CMD, DEV_WR, DEV_RD} sda_dev_state_t;
  typedef enum logic [1:0] {HOST_IDLE, HOST_HIGH, HOST_LOW, HOST_END} sda_host_state_t;
  typedef struct packed {
    logic [2:0] sclkSy;
    logic [1:0] csSy;
    logic [1:0] dinSy;
    logic [1:0] modSy;
    sda_dev_state_t state;
    logic [4:0] bitCnt;
    logic [4:0] width;
    logic [2:0] sel;
    logic [23:0] rx;
    logic [23:0] tx;
    logic [5:0] ones;
    logic [6:0] comm;
    logic [7:0] setup;
    logic [7:0] clk;
    logic [7:0] test;
    logic [15:0] data;
    logic [23:0] offs;
    logic [23:0] gain;
    logic readyN;
    logic dout;
    logic doutOe;
    logic [7:0] modDiv;
    logic modClkEn;
    logic [27:0] integ1;
    logic [27:0] integ2;
    logic [27:0] integ3;
    logic [27:0] dly1;
    logic [27:0] dly2;
    logic [27:0] dly3;
    logic [8:0] decCnt;
    logic [1:0] settle;
  } sda_dev_st_t;
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic awGot;
    logic [7:0] awAddr;
    logic wGot;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic [1:0] misoSy;
    logic [1:0] rdySy;
    sda_host_state_t state;
    logic [3:0] half;
    logic [5:0] bits;
    logic [5:0] cnt;
    logic [31:0] shift;
    logic [23:0] rxSh;
    logic [4:0] width;
    logic [7:0] lastCmd;
    logic [23:0] txData;
    logic [23:0] rxData;
    logic threeWire;
    logic busy;
    logic sclk;
    logic csN;
    logic mosi;
  } sda_host_st_t;

  // Data-phase width of each target; no-op has none
  function automatic logic [4:0] sda_reg_width(input logic [2:0] sel);
    case (sel)
      `SDA_SEL_DATA: sda_reg_width = `SDA_W16;
      `SDA_SEL_OFFS, `SDA_SEL_GAIN: sda_reg_width = `SDA_W24;
      `SDA_SEL_NOP: sda_reg_width = 5'h00;
      default: sda_reg_width = `SDA_W8;
    endcase
  endfunction : sda_reg_width
endpackage : sda_pkg

// >>> core/sda_link_if.sv
// Four-wire serial link between the converter and its host
`timescale 1ns/1ps
interface sda_link_if;
  logic sclk;
  logic csN;
  logic mosi;
  logic miso;
  logic misoOe;
  logic misoPin;
  logic readyN;
  // Undriven output line reads high
  assign misoPin = misoOe ? miso : 1'b1;
  modport dev(input sclk, input csN, input mosi, output miso, output misoOe, output readyN);
  modport host(output sclk, output csN, output mosi, input misoPin, input readyN);
endinterface : sda_link_if

// >>> core/sda_host_ctrl.sv
// Host end: AXI4-Lite controlled serial master for the converter
`timescale 1ns/1ps
`include "sda_consts.svh"
module sda_host_ctrl (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  sda_link_if.host link
);
  localparam sda_pkg::sda_host_st_t HOST_RST = '{state: sda_pkg::HOST_IDLE, sclk: 1'b1,
    csN: 1'b1, mosi: 1'b1, misoSy: 2'b11, rdySy: 2'b11, default: '0};
  sda_pkg::sda_host_st_t st_ff;
  sda_pkg::sda_host_st_t nxt_st;
  logic go;
  logic goOnes;
  logic [4:0] w;

  always_comb begin
    nxt_st = st_ff;
    go = 1'b0;
    goOnes = 1'b0;
    w = 5'h00;
    nxt_st.misoSy = {st_ff.misoSy[0], link.misoPin};
    nxt_st.rdySy = {st_ff.rdySy[0], link.readyN};
    if (awvalid && st_ff.awready) begin
      nxt_st.awGot = 1'b1;
      nxt_st.awAddr = awaddr;
    end
    if (wvalid && st_ff.wready) begin
      nxt_st.wGot = 1'b1;
      nxt_st.wData = wdata;
      nxt_st.wStrb = wstrb;
    end
    if (st_ff.bvalid && bready) begin
      nxt_st.bvalid = 1'b0;
    end
    if (st_ff.awGot && st_ff.wGot && !st_ff.bvalid) begin
      nxt_st.awGot = 1'b0;
      nxt_st.wGot = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = `SDA_OKAY;
      case (st_ff.awAddr)
        `SDA_A_CMD: go = st_ff.wStrb[0] && !st_ff.busy;
        `SDA_A_TX: begin
          for (int i = 0; i < 3; i++) begin
            if (st_ff.wStrb[i]) begin
              nxt_st.txData[i*8 +: 8] = st_ff.wData[i*8 +: 8];
            end
          end
        end
        `SDA_A_CTRL: begin
          if (st_ff.wStrb[0]) begin
            nxt_st.threeWire = st_ff.wData[1];
            goOnes = st_ff.wData[0] && !st_ff.busy;
          end
        end
        `SDA_A_RX, `SDA_A_STAT: nxt_st.bresp = `SDA_OKAY;
        default: nxt_st.bresp = `SDA_SLVERR;
      endcase
    end
    nxt_st.awready = !nxt_st.awGot && !nxt_st.bvalid;
    nxt_st.wready = !nxt_st.wGot && !nxt_st.bvalid;
    if (st_ff.rvalid && rready) begin
      nxt_st.rvalid = 1'b0;
    end
    if (arvalid && st_ff.arready) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp = `SDA_OKAY;
      case (araddr)
        `SDA_A_CMD: nxt_st.rdata = {24'h000000, st_ff.lastCmd};
        `SDA_A_TX: nxt_st.rdata = {8'h00, st_ff.txData};
        `SDA_A_RX: nxt_st.rdata = {8'h00, st_ff.rxData};
        `SDA_A_STAT: nxt_st.rdata = {30'h0, st_ff.rdySy[1], st_ff.busy};
        `SDA_A_CTRL: nxt_st.rdata = {30'h0, st_ff.threeWire, 1'b0};
        default: begin
          nxt_st.rdata = 32'h00000000;
          nxt_st.rresp = `SDA_SLVERR;
        end
      endcase
    end
    nxt_st.arready = !nxt_st.rvalid;
    if (go || goOnes) begin
      w = goOnes ? `SDA_W24 : sda_pkg::sda_reg_width(st_ff.wData[6:4]);
      nxt_st.width = w;
      nxt_st.lastCmd = goOnes ? 8'hFF : st_ff.wData[7:0];
      nxt_st.bits = {1'b0, w} + 6'h08;
      if (goOnes) begin
        nxt_st.shift = 32'hFFFFFFFF;
      end else if (st_ff.wData[`SDA_CMD_RW]) begin
        nxt_st.shift = {st_ff.wData[7:0], 24'h000000};
      end else begin
        nxt_st.shift = {st_ff.wData[7:0], st_ff.txData << (5'h18 - w)};
      end
      nxt_st.busy = 1'b1;
      nxt_st.csN = 1'b0;
      nxt_st.cnt = 6'h00;
      nxt_st.half = 4'h0;
      nxt_st.state = sda_pkg::HOST_HIGH;
    end
    if (st_ff.state != sda_pkg::HOST_IDLE) begin
      nxt_st.half = st_ff.half + 4'h1;
    end
    case (st_ff.state)
      sda_pkg::HOST_IDLE: nxt_st.csN = go || goOnes ? 1'b0 : !st_ff.threeWire;
      sda_pkg::HOST_HIGH: begin
        if (st_ff.half == `SDA_SCLK_HALF_M1) begin
          nxt_st.half = 4'h0;
          if (st_ff.cnt == st_ff.bits) begin
            nxt_st.state = sda_pkg::HOST_END;
          end else begin
            nxt_st.sclk = 1'b0;
            nxt_st.mosi = st_ff.shift[31];
            nxt_st.shift = {st_ff.shift[30:0], 1'b1};
            nxt_st.state = sda_pkg::HOST_LOW;
          end
        end
      end
      sda_pkg::HOST_LOW: begin
        if (st_ff.half == `SDA_SCLK_HALF_M1) begin
          nxt_st.half = 4'h0;
          nxt_st.sclk = 1'b1;
          nxt_st.rxSh = {st_ff.rxSh[22:0], st_ff.misoSy[1]};
          nxt_st.cnt = st_ff.cnt + 6'h01;
          nxt_st.state = sda_pkg::HOST_HIGH;
        end
      end
      sda_pkg::HOST_END: begin
        if (st_ff.half == `SDA_SCLK_HALF_M1) begin
          nxt_st.csN = !st_ff.threeWire;
          nxt_st.busy = 1'b0;
          nxt_st.rxData = st_ff.rxSh & (24'hFFFFFF >> (5'h18 - st_ff.width));
          nxt_st.state = sda_pkg::HOST_IDLE;
        end
      end
      default: nxt_st.state = sda_pkg::HOST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= HOST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign awready = st_ff.awready;
  assign wready = st_ff.wready;
  assign bvalid = st_ff.bvalid;
  assign bresp = st_ff.bresp;
  assign arready = st_ff.arready;
  assign rvalid = st_ff.rvalid;
  assign rresp = st_ff.rresp;
  assign rdata = st_ff.rdata;
  assign link.sclk = st_ff.sclk;
  assign link.csN = st_ff.csN;
  assign link.mosi = st_ff.mosi;
endmodule : sda_host_ctrl

// >>> core/sda_adc_dev.sv
// Converter end: serial register port, sinc3 decimator and result coding
// What this block does
// - Unipolar: straight binary from zero scale
// - Bipolar: offset binary, zero at mid-scale
// - Bipolar step twice unipolar, 16-bit span
// - Polarity bit picks transfer function
// - Modulator clock is master clock over 128, or 256 when halved
// - Sinc3 filter, three periods to settle
// - Word rate equals first notch frequency
// - Rate and notch bits move the notches
// - Settles three periods after sync released
// - Sample on rising, drive on falling edges
// - Every word shifted MSB first
// - Chip select high: float output, ignore
// - Three-wire host holds select low
// - Seven registers of 8, 16, 24 bits
// - Command byte: channel, direction, target
// - Data register holds latest result
// - Offset calibration applied, gain coefficient only stored
// - Command byte first, then register access
// - Back to command wait after transfer
// - 32 ones resynchronise, registers kept
// - Ready low on new result, high after read
// - Select bits decode the eight targets
// - Filter-sync hold stops and resets filter
//
// Decided for this implementation: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "sda_consts.svh"
module sda_adc_dev (
  input wire logic mclk,
  input wire logic arst_n,
  sda_link_if.dev link,
  input wire logic modBit,
  output logic modClkEn,
  output logic [1:0] chanSel,
  output logic [2:0] pgaGain,
  output logic powerDown
);
  localparam sda_pkg::sda_dev_st_t DEV_RST = '{state: sda_pkg::DEV_CMD,
    setup: `SDA_SETUP_RST, clk: `SDA_CLOCK_RST, offs: `SDA_OFFS_RST,
    gain: `SDA_GAIN_RST, readyN: 1'b1, sclkSy: 3'b111, csSy: 2'b11, default: '0};
  sda_pkg::sda_dev_st_t st_ff;
  sda_pkg::sda_dev_st_t nxt_st;
  logic rise;
  logic fall;
  logic din;
  logic newRes;
  logic readDone;
  logic [3:0] log2n;
  logic [9:0] nm1;
  logic [5:0] shAmt;
  logic [27:0] c1;
  logic [27:0] c2;
  logic [27:0] c3;
  logic [43:0] scaled;
  logic signed [20:0] code;
  logic signed [24:0] offDiff;
  logic signed [20:0] corr;
  logic [15:0] result;
  logic [23:0] wrVal;
  logic [23:0] rdVal;
  logic [4:0] w;
  logic [7:0] cmdByte;

  always_comb begin
    nxt_st = st_ff;
    newRes = 1'b0;
    readDone = 1'b0;
    rdVal = 24'h000000;
    w = 5'h00;
    cmdByte = {st_ff.rx[6:0], st_ff.dinSy[1]};
    wrVal = {st_ff.rx[22:0], st_ff.dinSy[1]};
    din = st_ff.dinSy[1];
    nxt_st.sclkSy = {st_ff.sclkSy[1:0], link.sclk};
    nxt_st.csSy = {st_ff.csSy[0], link.csN};
    nxt_st.dinSy = {st_ff.dinSy[0], link.mosi};
    nxt_st.modSy = {st_ff.modSy[0], modBit};
    // Edges count only while selected
    rise = st_ff.sclkSy[1] && !st_ff.sclkSy[2] && !st_ff.csSy[1];
    fall = !st_ff.sclkSy[1] && st_ff.sclkSy[2] && !st_ff.csSy[1];
    nxt_st.doutOe = !st_ff.csSy[1];
    // Modulator rate, optionally halved input clock
    nxt_st.modClkEn = 1'b0;
    if (st_ff.modDiv == (st_ff.clk[`SDA_CLOCK_HALVE] ? `SDA_MOD_DIV2_M1 : `SDA_MOD_DIV_M1)) begin
      nxt_st.modDiv = 8'h00;
      nxt_st.modClkEn = 1'b1;
    end else begin
      nxt_st.modDiv = st_ff.modDiv + 8'h01;
    end
    // Decimation ratio 2^log2n sets word rate and notch spacing
    log2n = `SDA_LOG2N_BASE + {3'h0, st_ff.clk[`SDA_CLOCK_BASE]} + {2'h0, st_ff.clk[1:0]};
    nm1 = (10'h001 << log2n) - 10'h001;
    shAmt = {1'b0, log2n, 1'b0} + {2'h0, log2n};
    c1 = st_ff.integ3 - st_ff.dly1;
    c2 = c1 - st_ff.dly2;
    c3 = c2 - st_ff.dly3;
    scaled = {c3, 16'h0000} >> shAmt;
    // Density 0..1 maps to -FS..+FS
    if (st_ff.setup[`SDA_SETUP_UNI]) begin
      code = $signed({1'b0, scaled[18:0], 1'b0}) - 21'sh010000;
    end else begin
      code = $signed({2'h0, scaled[18:0]});
    end
    offDiff = $signed({1'b0, st_ff.offs}) - $signed({1'b0, `SDA_OFFS_RST});
    corr = code - {{4{offDiff[24]}}, offDiff[24:8]};
    if (corr < 21'sh000000) begin
      result = 16'h0000;
    end else if (corr > 21'sh00FFFF) begin
      result = 16'hFFFF;
    end else begin
      result = corr[15:0];
    end
    if (st_ff.setup[`SDA_SETUP_HOLD]) begin
      nxt_st.integ1 = 28'h0000000;
      nxt_st.integ2 = 28'h0000000;
      nxt_st.integ3 = 28'h0000000;
      nxt_st.dly1 = 28'h0000000;
      nxt_st.dly2 = 28'h0000000;
      nxt_st.dly3 = 28'h0000000;
      nxt_st.decCnt = 9'h000;
      nxt_st.settle = 2'h0;
    end else if (st_ff.modClkEn) begin
      // Unpipelined chain, so the third word after release is exact
      nxt_st.integ1 = st_ff.integ1 + {27'h0, st_ff.modSy[1]};
      nxt_st.integ2 = st_ff.integ2 + nxt_st.integ1;
      nxt_st.integ3 = st_ff.integ3 + nxt_st.integ2;
      if (st_ff.decCnt == nm1[8:0]) begin
        nxt_st.decCnt = 9'h000;
        nxt_st.dly1 = st_ff.integ3;
        nxt_st.dly2 = c1;
        nxt_st.dly3 = c2;
        if (st_ff.settle != 2'h3) begin
          nxt_st.settle = st_ff.settle + 2'h1;
        end
        // First two words after release are discarded
        if (st_ff.settle >= `SDA_SETTLE_LAST) begin
          nxt_st.data = result;
          newRes = 1'b1;
        end
      end else begin
        nxt_st.decCnt = st_ff.decCnt + 9'h001;
      end
    end
    // Serial port
    if (rise) begin
      nxt_st.ones = din ? st_ff.ones + 6'h01 : 6'h00;
      nxt_st.rx = {st_ff.rx[22:0], din};
      nxt_st.bitCnt = st_ff.bitCnt + 5'h01;
      case (st_ff.state)
        sda_pkg::DEV_CMD: begin
          if (st_ff.bitCnt == 5'h00 && din) begin
            nxt_st.bitCnt = 5'h00;
          end else if (st_ff.bitCnt == 5'h07) begin
            nxt_st.bitCnt = 5'h00;
            nxt_st.comm = cmdByte[6:0];
            nxt_st.sel = cmdByte[6:4];
            w = sda_pkg::sda_reg_width(cmdByte[6:4]);
            nxt_st.width = w;
            case (cmdByte[6:4])
              `SDA_SEL_COMM: rdVal = {16'h0000, st_ff.readyN, st_ff.comm};
              `SDA_SEL_SETUP: rdVal = {16'h0000, st_ff.setup};
              `SDA_SEL_CLOCK: rdVal = {16'h0000, st_ff.clk};
              `SDA_SEL_DATA: rdVal = {8'h00, st_ff.data};
              `SDA_SEL_TEST: rdVal = {16'h0000, st_ff.test};
              `SDA_SEL_OFFS: rdVal = st_ff.offs;
              `SDA_SEL_GAIN: rdVal = st_ff.gain;
              default: rdVal = 24'h000000;
            endcase
            nxt_st.tx = rdVal << (5'h18 - w);
            if (w == 5'h00) begin
              nxt_st.state = sda_pkg::DEV_CMD;
            end else if (cmdByte[`SDA_CMD_RW]) begin
              nxt_st.state = sda_pkg::DEV_RD;
            end else begin
              nxt_st.state = sda_pkg::DEV_WR;
            end
          end
        end
        sda_pkg::DEV_WR: begin
          if (st_ff.bitCnt == st_ff.width - 5'h01) begin
            nxt_st.bitCnt = 5'h00;
            nxt_st.state = sda_pkg::DEV_CMD;
            case (st_ff.sel)
              `SDA_SEL_COMM: nxt_st.comm = wrVal[6:0];
              `SDA_SEL_SETUP: nxt_st.setup = wrVal[7:0];
              `SDA_SEL_CLOCK: nxt_st.clk = wrVal[7:0];
              `SDA_SEL_TEST: nxt_st.test = wrVal[7:0];
              `SDA_SEL_OFFS: nxt_st.offs = wrVal;
              `SDA_SEL_GAIN: nxt_st.gain = wrVal;
              default: nxt_st.test = st_ff.test;
            endcase
          end
        end
        sda_pkg::DEV_RD: begin
          if (st_ff.bitCnt == st_ff.width - 5'h01) begin
            nxt_st.bitCnt = 5'h00;
            nxt_st.state = sda_pkg::DEV_CMD;
            readDone = st_ff.sel == `SDA_SEL_DATA;
          end
        end
        default: nxt_st.state = sda_pkg::DEV_CMD;
      endcase
      if (st_ff.ones == `SDA_ONES_LAST && din) begin
        nxt_st.state = sda_pkg::DEV_CMD;
        nxt_st.bitCnt = 5'h00;
        nxt_st.ones = 6'h00;
        nxt_st.comm = st_ff.comm;
        nxt_st.setup = st_ff.setup;
        nxt_st.clk = st_ff.clk;
        nxt_st.test = st_ff.test;
        nxt_st.offs = st_ff.offs;
        nxt_st.gain = st_ff.gain;
      end
    end
    if (fall && st_ff.state == sda_pkg::DEV_RD) begin
      nxt_st.dout = st_ff.tx[23];
      nxt_st.tx = {st_ff.tx[22:0], 1'b0};
    end
    // A new result wins over a read finishing in the same cycle
    if (newRes) begin
      nxt_st.readyN = 1'b0;
    end else if (readDone) begin
      nxt_st.readyN = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= DEV_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign link.miso = st_ff.dout;
  assign link.misoOe = st_ff.doutOe;
  assign link.readyN = st_ff.readyN;
  assign modClkEn = st_ff.modClkEn;
  assign chanSel = st_ff.comm[1:0];
  assign pgaGain = st_ff.setup[5:3];
  assign powerDown = st_ff.comm[2];
endmodule : sda_adc_dev

// >>> tb/sda_link_chk.sv
// Protocol checks on the converter serial link
`timescale 1ns/1ps
module sda_link_chk (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic sclk,
  input wire logic csN,
  input wire logic mosi,
  input wire logic miso,
  input wire logic misoOe,
  input wire logic readyN
);
  logic sclkQ_ff;
  logic [5:0] rises_ff;
  // Clock rises within one select frame
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sclkQ_ff <= 1'b1;
      rises_ff <= 6'h00;
    end else begin
      sclkQ_ff <= sclk;
      rises_ff <= csN ? 6'h00 : rises_ff + {5'h00, sclk & ~sclkQ_ff};
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  float_cs_a: assert property (csN [*5] |-> !misoOe)
    else $error("out driven when idle");
  miso_fall_a: assert property (
    !csN && misoOe && $past(misoOe) && $changed(miso) |-> !sclk)
    else $error("out moved, clock high");
  mosi_hold_a: assert property (!csN && $rose(sclk) |-> $stable(mosi) [*4])
    else $error("in moved at rise");
  half_low_a: assert property ($fell(sclk) |-> (!sclk) [*8] ##1 sclk)
    else $error("low phase not 8");
  open_hold_a: assert property ($fell(csN) |-> sclk [*8])
    else $error("early clock fall");
  idle_high_a: assert property (csN |-> sclk)
    else $error("clock low when idle");
  frame_bits_a: assert property (
    $rose(csN) |-> rises_ff inside {6'h08, 6'h10, 6'h18, 6'h20, 6'h28})
    else $error("bad frame length");
  ready_rise_a: assert property ($rose(readyN) |-> !csN)
    else $error("ready cleared outside read");
  cover property ($rose(csN) && rises_ff == 6'h20);
  cover property ($fell(readyN));
  cover property ($rose(misoOe));
endmodule : sda_link_chk

// >>> tb/tb.sv
// Bench: host controller and converter joined over the serial link
`timescale 1ns/1ps
`include "sda_consts.svh"
module tb;
  logic mclk = 1'b0, arst_n = 1'b0, modBit = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
  logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0, monSclk = 1'b1, monCs = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rd, rdata;
  logic [3:0] wstrb = 4'hF;
  logic [1:0] pat = 2'h0, resp, bresp, rresp, chanSel;
  logic [15:0] monBits = 16'h0;
  logic [5:0] monCnt = 6'h00;
  logic awready, wready, bvalid, arready, rvalid, modClkEn, powerDown;
  logic [2:0] pgaGain;
  int nMismatch = 0, checks = 0;
  sda_link_if lnk();
  sda_host_ctrl i_sda_host_ctrl (.mclk(mclk), .arst_n(arst_n), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .link(lnk.host));
  sda_adc_dev i_sda_adc_dev (.mclk(mclk), .arst_n(arst_n), .link(lnk.dev), .modBit(modBit),
    .modClkEn(modClkEn), .chanSel(chanSel), .pgaGain(pgaGain), .powerDown(powerDown));
  sda_link_chk i_sda_link_chk (.mclk(mclk), .arst_n(arst_n), .sclk(lnk.sclk), .csN(lnk.csN),
    .mosi(lnk.mosi), .miso(lnk.miso), .misoOe(lnk.misoOe), .readyN(lnk.readyN));
  initial begin
    forever #10 mclk = ~mclk;
  end
  // Bitstream source; records host bits at each clock rise
  always @(posedge mclk) begin
    if (!pat[1]) begin
      modBit <= pat[0];
    end else if (modClkEn) begin
      modBit <= ~modBit;
    end
    monSclk <= lnk.sclk;
    monCs <= lnk.csN;
    if (!lnk.csN && monCs) begin
      monCnt <= 6'h00;
    end else if (!lnk.csN && lnk.sclk && !monSclk) begin
      monBits <= {monBits[14:0], lnk.mosi};
      monCnt <= monCnt + 6'h01;
    end
  end
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      nMismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task report_and_stop;
    $display("checks %0d mismatches %0d", checks, nMismatch);
    if (nMismatch == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop
  task tmo(input string what, input int n, input int lim);
    if (n >= lim) begin
      nMismatch++;
      $display("Error %s timed out", what);
      report_and_stop();
    end
  endtask : tmo
  task axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
    end while (bvalid !== 1'b1 && n < 100);
    tmo("write", n, 100);
    resp = bresp;
    bready <= 1'b0;
    @(posedge mclk);
  endtask : axi_wr
  task axi_rd(input logic [7:0] a);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
      n++;
    end while (rvalid !== 1'b1 && n < 100);
    tmo("read", n, 100);
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
    @(posedge mclk);
  endtask : axi_rd
  task wait_idle;
    int n;
    n = 0;
    do begin
      axi_rd(`SDA_A_STAT);
      n++;
    end while (rd[0] !== 1'b0 && n < 400);
    tmo("busy", n, 400);
  endtask : wait_idle
  task sop(input logic [2:0] sel, input logic isRd, input logic [1:0] ch, input logic [23:0] d);
    if (!isRd) axi_wr(`SDA_A_TX, {8'h00, d});
    axi_wr(`SDA_A_CMD, {24'h0, 1'b0, sel, isRd, 1'b0, ch});
    wait_idle();
    if (isRd) axi_rd(`SDA_A_RX);
  endtask : sop
  task t_defaults;
    logic [2:0] sels [6];
    logic [23:0] exps [6];
    sels = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h6, 3'h7};
    exps = '{24'h01, 24'h05, 24'h0, 24'h0, 24'h1F4000, 24'h5761AB};
    for (int i = 0; i < 6; i++) begin
      sop(sels[i], 1'b1, 2'h0, 24'h0);
      chk("reset value", rd, {8'h00, exps[i]});
    end
    axi_rd(8'h3C);
    chk("unmapped", {rd[29:0], resp}, 32'h2);
    axi_wr(8'h3C, 32'h0);
    chk("unmapped write", {30'h0, resp}, 32'h2);
    $display("defaults done");
  endtask : t_defaults
  task t_rw;
    sop(3'h1, 1'b0, 2'h2, 24'h2D);
    chk("frame", {10'h0, monCnt, monBits}, {10'h0, 6'h10, 16'h122D});
    chk("outputs", {26'h0, powerDown, chanSel, pgaGain}, 32'h15);
    sop(3'h5, 1'b0, 2'h2, 24'h0);
    chk("nop frame", {26'h0, monCnt}, 32'h8);
    sop(3'h7, 1'b0, 2'h2, 24'h123456);
    axi_wr(`SDA_A_CTRL, 32'h1);
    chk("write resp", {30'h0, resp}, 32'h0);
    wait_idle();
    chk("ones", {10'h0, monCnt, monBits}, {10'h0, 6'h20, 16'hFFFF});
    axi_rd(`SDA_A_CMD);
    chk("resync", rd, 32'hFF);
    sop(3'h1, 1'b1, 2'h2, 24'h0);
    chk("setup", rd, 32'h2D);
    sop(3'h7, 1'b1, 2'h2, 24'h0);
    chk("gain", rd, 32'h123456);
    $display("access done");
  endtask : t_rw
  task t_modclk;
    int n;
    logic [7:0] clks [2];
    clks = '{8'h08, 8'h00};
    for (int i = 0; i < 2; i++) begin
      sop(3'h2, 1'b0, 2'h0, {16'h0, clks[i]});
      for (int k = 0; k < 2; k++) begin
        n = 0;
        do begin
          @(posedge mclk);
          n++;
        end while (modClkEn !== 1'b1 && n < 600);
        tmo("modulator", n, 600);
      end
      chk("mod period", n, clks[i][3] ? 32'h100 : 32'h80);
    end
    $display("modulator done");
  endtask : t_modclk
  task t_conv(input logic [7:0] setup, input logic [1:0] p, input logic [15:0] exp);
    int n;
    pat <= p;
    sop(3'h1, 1'b0, 2'h0, {16'h0, setup});
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (lnk.readyN !== 1'b0 && n < 20000);
    tmo("result", n, 20000);
    chk("settle", {31'h0, n > 10000 && n < 13000}, 32'h1);
    sop(3'h3, 1'b1, 2'h0, 24'h0);
    chk("result", rd, {16'h0, exp});
    chk("ready", {31'h0, lnk.readyN}, 32'h1);
    sop(3'h1, 1'b0, 2'h0, {16'h0, setup | 8'h01});
    $display("conversion done");
  endtask : t_conv
  task t_three;
    axi_wr(`SDA_A_CTRL, 32'h2);
    repeat (4) @(posedge mclk);
    chk("select", {31'h0, lnk.csN}, 32'h0);
    sop(3'h1, 1'b1, 2'h0, 24'h0);
    chk("three wire", rd, 32'h05);
    axi_wr(`SDA_A_CMD, 32'h54);
    wait_idle();
    chk("power down", {29'h0, powerDown, chanSel}, 32'h4);
    $display("three wire done");
  endtask : t_three
  initial begin
    repeat (16) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    t_defaults();
    t_rw();
    t_modclk();
    t_conv(8'h04, 2'h1, 16'hFFFF);
    t_conv(8'h00, 2'h2, 16'h8000);
    t_conv(8'h04, 2'h0, 16'h0000);
    t_three();
    report_and_stop();
  end
endmodule : tb
